// ---- verilog/blmc_top.sv ----
// Boot loader command handler for RAM execute, RAM read and NVM programming
// Functional notes
// - Execute header: type 83, length 04, three offset bytes, MSB first.
// - Jump target is RAM base plus 24-bit offset.
// - Execute offset above RAM size minus four is refused with error.
// - No check for valid code at the jump target.
// - Stack pointer loaded with 1800.0400 before the jump.
// - System clock switched to PLL before the jump.
// - Pending interrupts cleared and watchdog re-enabled before the jump.
// - Link register zeroed; only a system reset returns to the loader.
// - Valid execute jumps at once and sends no reply; errors reply.
// - Read header: type 84, length 06, offset, reserved byte, count.
// - Read count is eight bits and at most 128.
// - Read data returned in a final block of type 80.
// - Read with offset or offset plus count outside RAM is refused.
// - Programming uses type 05; data comes in the following final block.
// - Page crossing or out of range programming writes nothing, reports error.
// - Partial unaligned programming keeps unsupplied page bytes.
// - Programming carries up to 128 bytes.
// - Programming offset is relative to NVM base 1100.0000, length 06.
// - Execute and read run regardless of protection.
// - Programming blocked on any read protection or write protected region.
module blmc_top #(
	parameter int unsigned RAM_BYTES    = 3072,
	parameter int unsigned NVM_BYTES    = 65536,
	parameter int unsigned PAGE_BYTES   = 128,
	parameter int unsigned REGION_BYTES = 16384,
	parameter int unsigned REGIONS      = 4
) (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               reset_n,
	// Loader link, received bytes
	input  wire logic               rx_valid,
	input  wire logic [7:0]         rx_data,
	output logic                    rx_ready,
	// Loader link, reply bytes
	output logic                    tx_valid,
	output logic [7:0]              tx_data,
	input  wire logic               tx_ready,
	// RAM read port, data one cycle after request
	output logic                    mem_rd_req,
	output logic [31:0]             mem_rd_addr,
	input  wire logic [7:0]         mem_rd_data,
	// NVM page assembly and programming
	output logic                    nvm_wr_strobe,
	output logic [31:0]             nvm_wr_addr,
	output logic [7:0]              nvm_wr_data,
	output logic                    nvm_commit,
	input  wire logic               nvm_done,
	input  wire logic               nvm_fail,
	// Protection state
	input  wire logic               prot_read_any,
	input  wire logic [REGIONS-1:0] prot_write,
	// Jump context to the core
	output logic                    sp_load,
	output logic [31:0]             sp_value,
	output logic                    clk_sel_pll,
	output logic                    irq_clear_all,
	output logic                    wdt_enable,
	output logic                    link_reg_clear,
	output logic [31:0]             link_reg_value,
	output logic                    jump_req,
	output logic [31:0]             jump_addr
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta;
	logic rst_sync_n;

	// Release is synchronised; assertion stays asynchronous
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	// Longest header kept; declared ahead of the storage that it sizes
	localparam int HDR_SIZE = blmc_pkg::HDR_BYTES;

	blmc_pkg::blmc_state_e state, next_state;
	logic [7:0]  hdr [HDR_SIZE];
	logic [7:0]  next_hdr [HDR_SIZE];
	logic [7:0]  blk_len, next_blk_len;
	logic [7:0]  rcv_cnt, next_rcv_cnt;
	logic [7:0]  cnt, next_cnt;
	logic [23:0] ptr, next_ptr;
	logic [7:0]  code, next_code;
	logic        rd_reply, next_rd_reply;
	logic        prog_ok, next_prog_ok;
	logic [7:0]  tx_byte, next_tx_byte;
	logic        next_nvm_wr_strobe;
	logic [31:0] next_nvm_wr_addr;
	logic [7:0]  next_nvm_wr_data;
	logic        next_nvm_commit;
	logic        prep, next_prep;
	logic        next_jump_req;
	logic [31:0] next_jump_addr;

	// ----------------------------------------------------------------
	// Header decode
	// ----------------------------------------------------------------
	logic [31:0] off32;
	logic [31:0] num32;
	logic [31:0] end32;
	logic        ram_rd_bad;
	logic        exec_bad;
	logic        nvm_bad;
	logic        num_bad;

	// True when the region holding the offset is write protected
	function automatic logic region_locked(input logic [31:0] off,
	                                       input logic [REGIONS-1:0] mask);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < REGIONS; i++) begin
			if (off / REGION_BYTES == i && mask[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// Offset and count from the stored header; 32-bit math avoids wrap
	always_comb begin
		off32 = {8'h00, hdr[blmc_pkg::HDR_ADDR0], hdr[blmc_pkg::HDR_ADDR1],
		         hdr[blmc_pkg::HDR_ADDR2]};
		num32 = {24'h00_0000, hdr[blmc_pkg::HDR_NUM]};
		end32 = off32 + num32;
		num_bad = num32 == 0 || num32 > blmc_pkg::MAX_COUNT;
		ram_rd_bad = off32 >= RAM_BYTES || end32 > RAM_BYTES;
		exec_bad = off32 > RAM_BYTES - blmc_pkg::EXEC_MARGIN;
		nvm_bad = off32 >= NVM_BYTES || end32 > NVM_BYTES ||
		          (off32 % PAGE_BYTES) + num32 > PAGE_BYTES;
	end

	// ----------------------------------------------------------------
	// Handshakes
	// ----------------------------------------------------------------
	// Receiver only listens while a block is being parsed, so the host
	// is held off during checks, programming and replies
	always_comb begin
		rx_ready = state == blmc_pkg::ST_IDLE || state == blmc_pkg::ST_HDR ||
		           state == blmc_pkg::ST_EOT_LEN ||
		           state == blmc_pkg::ST_EOT_TYPE ||
		           state == blmc_pkg::ST_EOT_DATA;
		tx_valid = state == blmc_pkg::ST_TX_LEN || state == blmc_pkg::ST_TX_TYPE ||
		           state == blmc_pkg::ST_TX_CODE || state == blmc_pkg::ST_TX_DATA;
		mem_rd_req = state == blmc_pkg::ST_RD_REQ;
		tx_data = tx_byte;
	end

	// ----------------------------------------------------------------
	// Next state and data
	// ----------------------------------------------------------------
	always_comb begin
		next_state         = state;
		next_hdr           = hdr;
		next_blk_len       = blk_len;
		next_rcv_cnt       = rcv_cnt;
		next_cnt           = cnt;
		next_ptr           = ptr;
		next_code          = code;
		next_rd_reply      = rd_reply;
		next_prog_ok       = prog_ok;
		next_tx_byte       = tx_byte;
		next_nvm_wr_strobe = 1'b0;
		next_nvm_wr_addr   = nvm_wr_addr;
		next_nvm_wr_data   = nvm_wr_data;
		next_nvm_commit    = 1'b0;
		next_prep          = 1'b0;
		next_jump_req      = 1'b0;
		next_jump_addr     = jump_addr;
		unique case (state)
			blmc_pkg::ST_IDLE: begin
				if (rx_valid && rx_data != 8'h00) begin
					next_blk_len = rx_data;
					next_rcv_cnt = 8'h00;
					next_state   = blmc_pkg::ST_HDR;
				end
			end
			blmc_pkg::ST_HDR: begin
				if (rx_valid) begin
					// Bytes beyond the longest header are counted, not kept
					if (rcv_cnt < 8'(HDR_SIZE)) begin
						next_hdr[rcv_cnt[2:0]] = rx_data;
					end
					next_rcv_cnt = rcv_cnt + 8'h01;
					if (rcv_cnt + 8'h01 == blk_len) begin
						next_state = blmc_pkg::ST_CHECK;
					end
				end
			end
			blmc_pkg::ST_CHECK: begin
				next_rd_reply = 1'b0;
				next_tx_byte  = blmc_pkg::LEN_ERR_REPLY;
				next_ptr      = off32[23:0];
				next_cnt      = hdr[blmc_pkg::HDR_NUM];
				next_state    = blmc_pkg::ST_TX_LEN;
				// Execute and read ignore protection entirely
				unique case (hdr[blmc_pkg::HDR_TYPE])
					blmc_pkg::MSG_RAM_EXEC: begin
						if (blk_len != blmc_pkg::LEN_EXEC) begin
							next_code = blmc_pkg::ERR_EXEC_PARAMS;
						end else if (exec_bad) begin
							next_code = blmc_pkg::ERR_ADDR_RANGE;
						end else begin
							// No probe of target contents is made
							next_state = blmc_pkg::ST_EXEC;
						end
					end
					blmc_pkg::MSG_RAM_READ: begin
						if (blk_len != blmc_pkg::LEN_RW || num_bad) begin
							next_code = blmc_pkg::ERR_RW_PARAMS;
						end else if (ram_rd_bad) begin
							next_code = blmc_pkg::ERR_ADDR_RANGE;
						end else begin
							next_rd_reply = 1'b1;
							next_tx_byte  = hdr[blmc_pkg::HDR_NUM] + 8'h01;
						end
					end
					blmc_pkg::MSG_NVM_PROG: begin
						// Verdict is held until the data block is drained
						next_prog_ok = 1'b0;
						if (prot_read_any || region_locked(off32, prot_write)) begin
							next_code = blmc_pkg::ERR_READ_PROT;
						end else if (blk_len != blmc_pkg::LEN_RW || num_bad) begin
							next_code = blmc_pkg::ERR_RW_PARAMS;
						end else if (nvm_bad) begin
							next_code = blmc_pkg::ERR_ADDR_RANGE;
						end else begin
							next_prog_ok = 1'b1;
							next_code    = blmc_pkg::ERR_SUCCESS;
						end
						next_state = blmc_pkg::ST_EOT_LEN;
					end
					default: begin
						// Other loader commands are handled elsewhere
						next_state = blmc_pkg::ST_IDLE;
					end
				endcase
			end
			blmc_pkg::ST_EXEC: begin
				next_prep      = 1'b1;
				next_jump_addr = blmc_pkg::RAM_BASE + off32;
				next_state     = blmc_pkg::ST_JUMP;
			end
			blmc_pkg::ST_JUMP: begin
				next_jump_req = 1'b1;
				next_state    = blmc_pkg::ST_HALT;
			end
			blmc_pkg::ST_HALT: begin
				// Loaded code owns the core; only reset leaves here
				next_state = blmc_pkg::ST_HALT;
			end
			blmc_pkg::ST_EOT_LEN: begin
				if (rx_valid) begin
					next_blk_len = rx_data;
					if (rx_data != cnt + 8'h01 && prog_ok) begin
						next_prog_ok = 1'b0;
						next_code    = blmc_pkg::ERR_RW_PARAMS;
					end
					next_state = rx_data == 8'h00 ? blmc_pkg::ST_TX_LEN
					                              : blmc_pkg::ST_EOT_TYPE;
				end
			end
			blmc_pkg::ST_EOT_TYPE: begin
				if (rx_valid) begin
					if (rx_data != blmc_pkg::MSG_FINAL && prog_ok) begin
						next_prog_ok = 1'b0;
						next_code    = blmc_pkg::ERR_RW_PARAMS;
					end
					next_blk_len = blk_len - 8'h01;
					next_state = blk_len == 8'h01 ? blmc_pkg::ST_TX_LEN
					                              : blmc_pkg::ST_EOT_DATA;
				end
			end
			blmc_pkg::ST_EOT_DATA: begin
				if (rx_valid) begin
					// Byte strobes into the page buffer leave other bytes as is
					if (prog_ok) begin
						next_nvm_wr_strobe = 1'b1;
						next_nvm_wr_addr   = blmc_pkg::NVM_BASE + {8'h00, ptr};
						next_nvm_wr_data   = rx_data;
						next_ptr           = ptr + 24'h00_0001;
					end
					next_blk_len = blk_len - 8'h01;
					if (blk_len == 8'h01) begin
						next_nvm_commit = prog_ok;
						next_state = prog_ok ? blmc_pkg::ST_PROG_WAIT
						                     : blmc_pkg::ST_TX_LEN;
					end
				end
			end
			blmc_pkg::ST_PROG_WAIT: begin
				if (nvm_done) begin
					next_code  = nvm_fail ? blmc_pkg::ERR_NVM_FAIL : blmc_pkg::ERR_SUCCESS;
					next_state = blmc_pkg::ST_TX_LEN;
				end
			end
			blmc_pkg::ST_TX_LEN: begin
				if (tx_ready) begin
					next_tx_byte = blmc_pkg::MSG_FINAL;
					next_state   = blmc_pkg::ST_TX_TYPE;
				end
			end
			blmc_pkg::ST_TX_TYPE: begin
				if (tx_ready) begin
					next_tx_byte = code;
					next_state   = rd_reply ? blmc_pkg::ST_RD_REQ : blmc_pkg::ST_TX_CODE;
				end
			end
			blmc_pkg::ST_TX_CODE: begin
				if (tx_ready) begin
					next_state = blmc_pkg::ST_IDLE;
				end
			end
			blmc_pkg::ST_RD_REQ: begin
				next_state = blmc_pkg::ST_RD_WAIT;
			end
			blmc_pkg::ST_RD_WAIT: begin
				next_tx_byte = mem_rd_data;
				next_state   = blmc_pkg::ST_TX_DATA;
			end
			blmc_pkg::ST_TX_DATA: begin
				if (tx_ready) begin
					next_ptr   = ptr + 24'h00_0001;
					next_cnt   = cnt - 8'h01;
					next_state = cnt == 8'h01 ? blmc_pkg::ST_IDLE : blmc_pkg::ST_RD_REQ;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state         <= blmc_pkg::ST_IDLE;
			hdr           <= '{default: 8'h00};
			blk_len       <= 8'h00;
			rcv_cnt       <= 8'h00;
			cnt           <= 8'h00;
			ptr           <= 24'h00_0000;
			code          <= blmc_pkg::ERR_SUCCESS;
			rd_reply      <= 1'b0;
			prog_ok       <= 1'b0;
			tx_byte       <= 8'h00;
			nvm_wr_strobe <= 1'b0;
			nvm_wr_addr   <= 32'h0000_0000;
			nvm_wr_data   <= 8'h00;
			nvm_commit    <= 1'b0;
			prep          <= 1'b0;
			jump_req      <= 1'b0;
			jump_addr     <= 32'h0000_0000;
			mem_rd_addr   <= 32'h0000_0000;
		end else begin
			state         <= next_state;
			hdr           <= next_hdr;
			blk_len       <= next_blk_len;
			rcv_cnt       <= next_rcv_cnt;
			cnt           <= next_cnt;
			ptr           <= next_ptr;
			code          <= next_code;
			rd_reply      <= next_rd_reply;
			prog_ok       <= next_prog_ok;
			tx_byte       <= next_tx_byte;
			nvm_wr_strobe <= next_nvm_wr_strobe;
			nvm_wr_addr   <= next_nvm_wr_addr;
			nvm_wr_data   <= next_nvm_wr_data;
			nvm_commit    <= next_nvm_commit;
			prep          <= next_prep;
			jump_req      <= next_jump_req;
			jump_addr     <= next_jump_addr;
			mem_rd_addr   <= blmc_pkg::RAM_BASE + {8'h00, next_ptr};
		end
	end

	// ----------------------------------------------------------------
	// Jump preparation, one cycle ahead of the jump itself
	// ----------------------------------------------------------------
	always_comb begin
		sp_load        = prep;
		sp_value       = blmc_pkg::STACK_INIT;
		clk_sel_pll    = prep;
		irq_clear_all  = prep;
		wdt_enable     = prep;
		link_reg_clear = prep;
		link_reg_value = blmc_pkg::LINK_ZERO;
	end
endmodule

// ---- shared/blmc_pkg.sv ----
// Constants, codes and state encoding for the boot loader memory command handler
package blmc_pkg;
	// ----------------------------------------------------------------
	// Message types and fixed header lengths
	// ----------------------------------------------------------------
	localparam logic [7:0] MSG_RAM_EXEC  = 8'h83;
	localparam logic [7:0] MSG_RAM_READ  = 8'h84;
	localparam logic [7:0] MSG_NVM_PROG  = 8'h05;
	localparam logic [7:0] MSG_FINAL     = 8'h80;
	localparam logic [7:0] LEN_EXEC      = 8'h04;
	localparam logic [7:0] LEN_RW        = 8'h06;
	localparam logic [7:0] LEN_ERR_REPLY = 8'h02;

	// ----------------------------------------------------------------
	// Header byte positions after the length byte
	// ----------------------------------------------------------------
	localparam int HDR_TYPE  = 0;
	localparam int HDR_ADDR0 = 1;
	localparam int HDR_ADDR1 = 2;
	localparam int HDR_ADDR2 = 3;
	localparam int HDR_NUM   = 5;
	localparam int HDR_BYTES = 6;

	// ----------------------------------------------------------------
	// Memory map and jump context
	// ----------------------------------------------------------------
	localparam logic [31:0] RAM_BASE   = 32'h1800_0000;
	localparam logic [31:0] NVM_BASE   = 32'h1100_0000;
	localparam logic [31:0] STACK_INIT = 32'h1800_0400;
	localparam logic [31:0] LINK_ZERO  = 32'h0000_0000;
	localparam int unsigned EXEC_MARGIN = 4;
	localparam int unsigned MAX_COUNT   = 128;

	// ----------------------------------------------------------------
	// Reply codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ERR_SUCCESS     = 8'h00;
	localparam logic [7:0] ERR_READ_PROT   = 8'h01;
	localparam logic [7:0] ERR_ADDR_RANGE  = 8'h02;
	localparam logic [7:0] ERR_RW_PARAMS   = 8'h03;
	localparam logic [7:0] ERR_EXEC_PARAMS = 8'h04;
	localparam logic [7:0] ERR_NVM_FAIL    = 8'h05;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_HDR       = 4'h1,
		ST_CHECK     = 4'h2,
		ST_EXEC      = 4'h3,
		ST_JUMP      = 4'h4,
		ST_HALT      = 4'h5,
		ST_EOT_LEN   = 4'h6,
		ST_EOT_TYPE  = 4'h7,
		ST_EOT_DATA  = 4'h8,
		ST_PROG_WAIT = 4'h9,
		ST_TX_LEN    = 4'hA,
		ST_TX_TYPE   = 4'hB,
		ST_TX_CODE   = 4'hC,
		ST_RD_REQ    = 4'hD,
		ST_RD_WAIT   = 4'hE,
		ST_TX_DATA   = 4'hF
	} blmc_state_e;
endpackage

// ---- verilog/blmc_fix.sv ----
// Spare design file; all logic of the handler lives in the top module

// ---- verification/blmc_properties.sv ----
// Concurrent checks on the ports of the boot loader memory command handler
module blmc_properties #(
	parameter int unsigned RAM_BYTES = 3072,
	parameter int unsigned NVM_BYTES = 65536
) (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// Link
	input wire logic        rx_ready,
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_ready,
	// Memories and protection
	input wire logic        mem_rd_req,
	input wire logic [31:0] mem_rd_addr,
	input wire logic        nvm_wr_strobe,
	input wire logic [31:0] nvm_wr_addr,
	input wire logic        nvm_commit,
	input wire logic        prot_read_any,
	// Jump context
	input wire logic        sp_load,
	input wire logic [31:0] sp_value,
	input wire logic        clk_sel_pll,
	input wire logic        irq_clear_all,
	input wire logic        wdt_enable,
	input wire logic        link_reg_clear,
	input wire logic [31:0] link_reg_value,
	input wire logic        jump_req,
	input wire logic [31:0] jump_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	// -----------------------------------------------------------
	// One clock domain, so clock and disable are given once
	// -----------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	a_prep_then_jump : assert property (sp_load |=> jump_req)
		else $error("jump missing one cycle after prep pulse");
	a_prep_together : assert property (sp_load |-> clk_sel_pll && irq_clear_all && wdt_enable)
		else $error("prep pulses not aligned");
	a_stack_value : assert property (sp_load |-> sp_value == 32'h1800_0400)
		else $error("stack pointer value wrong at prep");
	a_link_zero : assert property (sp_load |-> link_reg_clear && link_reg_value == 32'h0)
		else $error("link register not zeroed at prep");
	a_jump_window : assert property (jump_req |-> jump_addr >= 32'h1800_0000 &&
		jump_addr <= 32'h1800_0000 + RAM_BYTES - 4) else $error("jump target outside RAM");
	a_halt_after : assert property (jump_req |=> (!rx_ready && !tx_valid) [*8])
		else $error("link active after jump");
	a_read_in_ram : assert property (mem_rd_req |-> mem_rd_addr >= 32'h1800_0000 &&
		mem_rd_addr < 32'h1800_0000 + RAM_BYTES) else $error("read outside RAM");
	a_prog_in_nvm : assert property (nvm_wr_strobe |-> nvm_wr_addr >= 32'h1100_0000 &&
		nvm_wr_addr < 32'h1100_0000 + NVM_BYTES) else $error("program outside NVM");
	a_prog_unprot : assert property (nvm_wr_strobe || nvm_commit |-> !prot_read_any)
		else $error("programming while read protected");
	a_tx_holds : assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte dropped before acceptance");
endmodule

bind blmc_top blmc_properties #(
	.RAM_BYTES(RAM_BYTES),
	.NVM_BYTES(NVM_BYTES)
) chk_u (
	.clk_sys, .reset_n, .rx_ready, .tx_valid, .tx_data, .tx_ready, .mem_rd_req,
	.mem_rd_addr, .nvm_wr_strobe, .nvm_wr_addr, .nvm_commit, .prot_read_any, .sp_load,
	.sp_value, .clk_sel_pll, .irq_clear_all, .wdt_enable, .link_reg_clear,
	.link_reg_value, .jump_req, .jump_addr
);

// ---- verification/blmc_host.sv ----
// Host tool model that drives the loader link byte by byte
module blmc_host (
	// Clock
	input  wire logic       clk_sys,
	// Bytes to the device
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       rx_ready,
	// Bytes from the device
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int stall = 1; // Cycles the host holds off before each reply byte

	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b0;
	end

	// Offer a byte and hold it until the device takes it
	task automatic put(input logic [7:0] b);
		rx_valid <= 1'b1;
		rx_data  <= b;
		@(posedge clk_sys);
		while (!rx_ready) @(posedge clk_sys);
	endtask

	// Length byte then its bytes; released line carries no stale byte
	task automatic send(input logic [7:0] blk [$]);
		foreach (blk[i]) put(blk[i]);
		rx_valid <= 1'b0;
		rx_data  <= ~blk[blk.size()-1];
	endtask

	// Take one reply byte; the wait is bounded, a missing byte reads as unknown
	task automatic get(output logic [7:0] b);
		int n;
		n = 0;
		repeat (stall) @(posedge clk_sys);
		tx_ready <= 1'b1;
		@(posedge clk_sys);
		while (!tx_valid && n < 2000) begin
			n++;
			@(posedge clk_sys);
		end
		b = tx_valid ? tx_data : 8'hXX;
		tx_ready <= 1'b0;
		@(posedge clk_sys);
	endtask
endmodule

// ---- verification/blmc_top_test.sv ----
// Self-checking bench for the boot loader memory command handler
module blmc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned RAM = 3072;
	logic        clk_sys, reset_n, rx_valid, rx_ready, tx_valid, tx_ready, mem_rd_req;
	logic        nvm_wr_strobe, nvm_commit, nvm_done, nvm_fail, prot_read_any, fail_cfg;
	logic        sp_load, clk_sel_pll, irq_clear_all, wdt_enable, link_reg_clear, jump_req;
	logic [7:0]  rx_data, tx_data, mem_rd_data, nvm_wr_data, first_dat;
	logic [31:0] mem_rd_addr, nvm_wr_addr, sp_value, link_reg_value, jump_addr, first_wr;
	logic [3:0]  prot_write, done_sr;
	int          strobes, commits, bad_count = 0, checked = 0, seed = 37;
	int          preps = 0, jumps = 0;

	blmc_top dut_u (
		.clk_sys, .reset_n, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
		.mem_rd_req, .mem_rd_addr, .mem_rd_data, .nvm_wr_strobe, .nvm_wr_addr, .nvm_wr_data,
		.nvm_commit, .nvm_done, .nvm_fail, .prot_read_any, .prot_write, .sp_load, .sp_value,
		.clk_sel_pll, .irq_clear_all, .wdt_enable, .link_reg_clear, .link_reg_value,
		.jump_req, .jump_addr
	);
	blmc_host host_u (.clk_sys, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// -----------------------------------------------------------
	// Far-side memories
	// -----------------------------------------------------------
	function automatic logic [7:0] ram_byte(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hA5;
	endfunction

	// RAM answers one cycle after a request, idle data keeps toggling
	always @(posedge clk_sys) begin
		mem_rd_data <= mem_rd_req ? ram_byte(mem_rd_addr) : ~mem_rd_data;
		done_sr     <= {done_sr[2:0], nvm_commit};
		nvm_done    <= done_sr[3];
		nvm_fail    <= fail_cfg;
		if (nvm_wr_strobe) begin
			if (strobes == 0) first_wr <= nvm_wr_addr;
			if (strobes == 0) first_dat <= nvm_wr_data;
			strobes <= strobes + 1;
		end
		if (nvm_commit) commits <= commits + 1;
		// Whole jump context must arrive in one pulse with its fixed values
		if (sp_load && clk_sel_pll && irq_clear_all && wdt_enable && link_reg_clear &&
		    sp_value == 32'h1800_0400 && link_reg_value == 32'h0) preps <= preps + 1;
		if (jump_req) jumps <= jumps + 1;
	end

	// -----------------------------------------------------------
	// Comparisons and protocol helpers
	// -----------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic hdr(input logic [7:0] len, ty, input logic [23:0] off, input logic [7:0] n);
		logic [7:0] q [$];
		q = {len, ty, off[23:16], off[15:8], off[7:0]};
		if (len == 8'h06) q = {q, 8'h00, n};
		@(posedge clk_sys);
		host_u.send(q);
	endtask

	// Status reply is always two bytes after its length
	task automatic reply(input logic [7:0] code);
		logic [7:0] b;
		host_u.get(b);
		chk8(b, 8'h02);
		host_u.get(b);
		chk8(b, 8'h80);
		host_u.get(b);
		chk8(b, code);
	endtask

	task automatic rd_ok(input logic [23:0] off, input logic [7:0] n);
		logic [7:0] b;
		hdr(8'h06, 8'h84, off, n);
		host_u.get(b);
		chk8(b, n + 8'h01);
		host_u.get(b);
		chk8(b, 8'h80);
		for (int i = 0; i < n; i++) begin
			host_u.get(b);
			chk8(b, ram_byte(32'h1800_0000 + off + i));
		end
	endtask

	// Data follows in a final block; strobes only when the request is good
	task automatic prog(input logic [23:0] off, input logic [7:0] n, input logic [7:0] code);
		logic [7:0] q [$];
		logic       ok;
		ok = (code == 8'h00) || (code == 8'h05);
		q = {n + 8'h01, 8'h80};
		for (int i = 0; i < n; i++) q.push_back(8'($random(seed)));
		strobes = 0;
		commits = 0;
		hdr(8'h06, 8'h05, off, n);
		@(posedge clk_sys);
		host_u.send(q);
		reply(code);
		chk32(strobes, ok ? 32'(n) : 32'h0);
		chk32(commits, {31'h0, ok});
		if (ok) chk32(first_wr, 32'h1100_0000 + off);
		if (ok) chk8(first_dat, q[2]);
	endtask

	task automatic test_done();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Hang guard at 20000 cycles, several times the expected run of some three thousand cycles
	initial begin
		#200_000;
		bad_count++;
		test_done();
	end

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		logic [7:0]  n;
		logic [23:0] off;
		{reset_n, prot_read_any, prot_write, fail_cfg, done_sr} = '0;
		{mem_rd_data, nvm_done, nvm_fail, strobes, commits, first_wr} = '0;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		// Random reads; protection toggled since reads ignore it
		repeat (6) begin
			n = 8'(1 + {$random(seed)} % 128);
			off = 24'({$random(seed)} % (RAM - n + 1));
			prot_read_any <= 1'($random(seed));
			rd_ok(off, n);
		end
		rd_ok(24'(RAM - 128), 8'd128);
		hdr(8'h06, 8'h84, 24'h0, 8'h00);
		reply(8'h03);
		hdr(8'h06, 8'h84, 24'h0, 8'h81);
		reply(8'h03);
		hdr(8'h06, 8'h84, 24'(RAM - 1), 8'h02);
		reply(8'h02);
		hdr(8'h06, 8'h84, 24'(RAM), 8'h01);
		reply(8'h02);
		prot_read_any <= 1'b0;
		// Random partial writes kept within one page
		repeat (3) begin
			n = 8'(1 + {$random(seed)} % 16);
			off = 24'({$random(seed)} % 256 * 128 + {$random(seed)} % (129 - n));
			prog(off, n, 8'h00);
		end
		prog(24'h000180, 8'd128, 8'h00);
		prog(24'h0001F0, 8'd17, 8'h02);
		prog(24'h010000, 8'd1, 8'h02);
		prog(24'h000000, 8'h81, 8'h03);
		fail_cfg <= 1'b1;
		prog(24'h000010, 8'd4, 8'h05);
		fail_cfg <= 1'b0;
		prot_write <= 4'h2;
		prog(24'h004000, 8'd2, 8'h01);
		prog(24'h000000, 8'd2, 8'h00);
		prot_write <= 4'h0;
		prot_read_any <= 1'b1;
		prog(24'h000000, 8'd2, 8'h01);
		prot_read_any <= 1'b0;
		// Execute errors, then the highest legal target, which ends the session
		hdr(8'h04, 8'h83, 24'(RAM - 3), 8'h00);
		reply(8'h02);
		hdr(8'h06, 8'h83, 24'h0, 8'h00);
		reply(8'h04);
		hdr(8'h04, 8'h83, 24'(RAM - 4), 8'h00);
		for (int i = 0; i < 20 && jump_req !== 1'b1; i++) @(posedge clk_sys);
		chk32(jump_addr, 32'h1800_0000 + RAM - 4);
		chk8({7'h0, tx_valid}, 8'h00);
		repeat (10) @(posedge clk_sys);
		chk8({7'h0, rx_ready}, 8'h00);
		chk32(preps, 32'h1);
		chk32(jumps, 32'h1);
		test_done();
	end
endmodule
